/* core/vram_control.sv */
// control decode of a dual-port video dram with serial buffer
// assumes strobes come from an outside controller, sampled on aclk
// Summary of operation
// - transfer direction: write_select high reads row to buffer, low writes back.
// - special_function_select latched at row and column strobe falls.
// - write data taken at column fall (early) or write_select fall (late).
// - random_dq driven only while column_strobe and transfer_output_enable low.
// - random_dq floats for the whole of a transfer cycle.
// - write mask captured from random_dq at row_strobe fall.
// - buffer direction: output after read transfer, input after write or pseudo.
// - serial pointer counts upward and wraps modulo 512.
// - one serial word moves per serial_clock rising edge.
// - serial_enable gates serial_dq in both directions.
// - write transfer with serial_enable inactive and select low moves no data: input mode, pointer from tap.
// - split mode: flag shows which half the pointer is in.
// - after a normal transfer the flag shows the half of the tap.
// - column strobe low at row fall gives internal-counter refresh.
// - write_select low: select low loads mask, high reuses it; block write.
// - write_select high: unmasked or block write, or mask/color load.
// - data and masks taken at later strobe fall; high bit enables.
// - hidden refresh keeps read data driven, refreshes internal row.
// - page mode fetches data as soon as column address is valid.
// - block write column mask bit n enables column with low bits n.
// - color register holds until the next color load.
// - nine row bits at row fall, nine column bits at column fall.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module vram_control (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        row_strobe_n,
  input  wire logic        column_strobe_n,
  input  wire logic        transfer_output_enable_n,
  input  wire logic        write_select_n,
  input  wire logic        special_function_select,
  input  wire logic        serial_enable_n,
  input  wire logic        serial_clock,
  input  wire logic [8:0]  address,
  input  wire logic [3:0]  random_dq_in,
  output logic [3:0]       random_dq_out,
  output logic             random_dq_oe,
  input  wire logic [3:0]  serial_dq_in,
  output logic [3:0]       serial_dq_out,
  output logic             serial_dq_oe,
  output logic             split_half_flag
);

  localparam vram_pkg::state_t ST_RESET = '{
    prev: vram_pkg::PINS_IDLE, cyc: vram_pkg::CYC_IDLE,
    xk: vram_pkg::XK_READ, ser_en: 1'b1, default: '0};

  vram_pkg::state_t st;
  vram_pkg::state_t next_st;
  vram_pkg::pins_t  pin_raw;
  vram_pkg::pins_t  pin;

  logic [3:0] dram [0:vram_pkg::DRAM_WORDS-1];
  logic [3:0] sbuf [0:vram_pkg::BUF_WORDS-1];

  logic       ras_fall;
  logic       ras_rise;
  logic       cas_fall;
  logic       we_fall;
  logic       clk_rise;
  logic       aw_ok;
  logic       dram_wr;
  logic       blk;
  logic [3:0] col_sel;
  logic [8:0] wr_col;
  logic [3:0] wr_data;
  logic [3:0] wr_bits;
  logic       buf_wr;
  logic       copy_go;
  logic       copy_last;
  logic       finish;
  logic       color_load;

  function automatic logic [3:0] col_onehot(input logic [1:0] c);
    col_onehot = 4'h1 << c;
  endfunction

  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == vram_pkg::OFS_CTRL) || (a == vram_pkg::OFS_STATUS) ||
              (a == vram_pkg::OFS_MASKS);
  endfunction

  // every pin passes two flops before use
  assign pin_raw = '{ras_n: row_strobe_n, cas_n: column_strobe_n,
    xfer_n: transfer_output_enable_n, we_n: write_select_n,
    fsel: special_function_select, ser_gate_n: serial_enable_n,
    ser_clk: serial_clock, addr: address, dq: random_dq_in,
    sdq: serial_dq_in};

  pin_sync #(
    .W       ($bits(vram_pkg::pins_t)),
    .RST_VAL (vram_pkg::PINS_IDLE)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pin_raw),
    .q       (pin)
  );

  // strobe edges against the previous snapshot
  assign ras_fall = st.prev.ras_n && !pin.ras_n;
  assign ras_rise = !st.prev.ras_n && pin.ras_n;
  assign cas_fall = st.prev.cas_n && !pin.cas_n;
  assign we_fall  = st.prev.we_n && !pin.we_n;
  assign clk_rise = !st.prev.ser_clk && pin.ser_clk;
  assign aw_ok    = awvalid && wvalid && !st.bvalid;

  // next-state logic for bus, serial port and strobe cycles
  always_comb
  begin
    next_st    = st;
    next_st.prev = pin;
    dram_wr    = 1'b0;
    blk        = 1'b0;
    col_sel    = 4'h0;
    wr_col     = st.col;
    wr_data    = 4'h0;
    wr_bits    = 4'h0;
    buf_wr     = 1'b0;
    copy_go    = 1'b0;
    copy_last  = 1'b0;
    finish     = 1'b0;
    color_load = 1'b0;
    if (st.bvalid && bready)
      next_st.bvalid = 1'b0;
    if (aw_ok)
    begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = reg_hit(awaddr) ? vram_pkg::RESP_OKAY
                                       : vram_pkg::RESP_SLVERR;
      if (awaddr == vram_pkg::OFS_CTRL && wstrb[0])
        next_st.ser_en = wdata[vram_pkg::CTRL_SER_EN];
    end
    if (st.rvalid && rready)
      next_st.rvalid = 1'b0;
    if (arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = reg_hit(araddr) ? vram_pkg::RESP_OKAY
                                       : vram_pkg::RESP_SLVERR;
      case (araddr)
        vram_pkg::OFS_CTRL:   next_st.rdata = {31'h0, st.ser_en};
        vram_pkg::OFS_STATUS: next_st.rdata = {7'h00, st.rfsh_row, 3'h0,
          st.cyc == vram_pkg::CYC_COPY, st.split_flag, st.split_mode,
          st.out_mode, st.ptr};
        vram_pkg::OFS_MASKS:  next_st.rdata = {24'h0, st.color, st.mask};
        default:              next_st.rdata = 32'h0;
      endcase
    end
    // serial port, one word per clock rise
    if (clk_rise)
    begin
      next_st.ptr = st.ptr + vram_pkg::PTR_STEP;
      if (st.out_mode)
        next_st.ser_out = sbuf[st.ptr];
      else
        buf_wr = !pin.ser_gate_n;
      if (st.split_mode)
        next_st.split_flag = next_st.ptr[vram_pkg::HALF_BIT];
    end
    // strobe cycles; a running copy ignores new row strobes
    if (st.cyc != vram_pkg::CYC_COPY && ras_fall)
    begin
      next_st.row     = pin.addr;
      next_st.we_ras  = pin.we_n;
      next_st.fsel_ras = pin.fsel;
      next_st.wr_done = 1'b0;
      if (!pin.cas_n)
      begin
        next_st.cyc      = vram_pkg::CYC_REFR;
        next_st.rfsh_row = st.rfsh_row + vram_pkg::PTR_STEP;
      end
      else if (!pin.xfer_n)
      begin
        next_st.cyc = vram_pkg::CYC_XFER;
        if (pin.we_n)
          next_st.xk = pin.fsel ? vram_pkg::XK_SPLIT : vram_pkg::XK_READ;
        else if (!pin.fsel && pin.ser_gate_n)
          next_st.xk = vram_pkg::XK_PSEUDO;
        else
          next_st.xk = vram_pkg::XK_WRITE;
      end
      else
      begin
        next_st.cyc = vram_pkg::CYC_RAND;
        if (!pin.we_n && !pin.fsel)
          next_st.mask = pin.dq;
      end
    end
    else if (st.cyc != vram_pkg::CYC_COPY && ras_rise)
      next_st.cyc = vram_pkg::CYC_IDLE;
    else
    begin
      case (st.cyc)
        vram_pkg::CYC_RAND:
        begin
          if (pin.cas_n)
            next_st.rd_data = dram[{st.row, pin.addr}];
          if (cas_fall)
          begin
            next_st.col     = pin.addr;
            next_st.fsel_cas = pin.fsel;
          end
          // later of the two falls takes the data
          if (!st.wr_done && ((cas_fall && !pin.we_n) ||
              (we_fall && !pin.cas_n)))
          begin
            next_st.wr_done = 1'b1;
            wr_col = next_st.col;
            blk    = next_st.fsel_cas;
            if (st.fsel_ras && st.we_ras)
            begin
              if (blk)
              begin
                next_st.color = pin.dq;
                color_load    = 1'b1;
              end
              else
                next_st.mask = pin.dq;
            end
            else
            begin
              dram_wr = 1'b1;
              wr_bits = st.we_ras ? vram_pkg::MASK_ALL : st.mask;
              if (blk)
              begin
                col_sel = pin.dq;
                wr_data = st.color;
              end
              else
              begin
                col_sel = col_onehot(wr_col[1:0]);
                wr_data = pin.dq;
              end
            end
          end
        end
        vram_pkg::CYC_XFER:
        begin
          if (cas_fall && !st.wr_done)
          begin
            next_st.tap = pin.addr;
            if (st.xk == vram_pkg::XK_PSEUDO)
              finish = 1'b1;
            else
            begin
              next_st.cyc = vram_pkg::CYC_COPY;
              next_st.idx = (st.xk == vram_pkg::XK_SPLIT) ?
                {~st.ptr[vram_pkg::HALF_BIT], vram_pkg::HALF_FIRST} :
                vram_pkg::BUF_FIRST;
            end
          end
        end
        vram_pkg::CYC_COPY:
        begin
          copy_go   = 1'b1;
          copy_last = (st.xk == vram_pkg::XK_SPLIT) ?
            (st.idx[7:0] == vram_pkg::HALF_LAST) :
            (st.idx == vram_pkg::PTR_LAST);
          next_st.idx = st.idx + vram_pkg::PTR_STEP;
          if (copy_last)
          begin
            finish      = 1'b1;
            next_st.cyc = pin.ras_n ? vram_pkg::CYC_IDLE
                                    : vram_pkg::CYC_XFER;
          end
        end
        default: ;
      endcase
    end
    // end of a transfer sets direction and half flag, and the pointer except on a split
    if (finish)
    begin
      next_st.wr_done  = 1'b1;
      next_st.out_mode = (st.xk == vram_pkg::XK_READ) ||
                         (st.xk == vram_pkg::XK_SPLIT);
      if (st.xk == vram_pkg::XK_SPLIT)
      begin
        next_st.split_mode = 1'b1;
        next_st.split_flag = next_st.ptr[vram_pkg::HALF_BIT];
      end
      else
      begin
        next_st.split_mode = 1'b0;
        next_st.ptr        = next_st.tap;
        next_st.split_flag = next_st.tap[vram_pkg::HALF_BIT];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  // array and buffer writes, no reset on storage
  always_ff @(posedge aclk)
  begin
    for (int j = 0; j < vram_pkg::DQ_W; j++)
    begin
      if (dram_wr && col_sel[j])
        dram[{st.row, wr_col[8:vram_pkg::BLK_LSB], 2'(j)}] <=
          (dram[{st.row, wr_col[8:vram_pkg::BLK_LSB], 2'(j)}] & ~wr_bits) |
          (wr_data & wr_bits);
    end
    if (copy_go && st.xk == vram_pkg::XK_WRITE)
      dram[{st.row, st.idx}] <= sbuf[st.idx];
    if (buf_wr)
      sbuf[st.ptr] <= pin.sdq;
    if (copy_go && st.xk != vram_pkg::XK_WRITE)
      sbuf[st.idx] <= dram[{st.row, st.idx}];
  end

  // pin and bus outputs
  assign random_dq_out   = st.rd_data;
  assign random_dq_oe    = !st.prev.cas_n && !st.prev.xfer_n &&
                           st.cyc != vram_pkg::CYC_XFER &&
                           st.cyc != vram_pkg::CYC_COPY;
  assign serial_dq_out   = st.ser_out;
  assign serial_dq_oe    = st.out_mode && !st.prev.ser_gate_n && st.ser_en;
  assign split_half_flag = st.split_flag;
  assign awready = aw_ok;
  assign wready  = aw_ok;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = !st.rvalid;
  assign rvalid  = st.rvalid;
  assign rresp   = st.rresp;
  assign rdata   = st.rdata;

  // checks on the decode
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_dq_drive_cond: assert property (random_dq_oe |->
    $past(!pin.cas_n) && $past(!pin.xfer_n))
    else $error("random dq driven without both enables low");
  a_dq_float_xfer: assert property (
    (st.cyc == vram_pkg::CYC_XFER) |-> !random_dq_oe)
    else $error("random dq driven in transfer");
  a_mask_on_ras: assert property (ras_fall &&
    st.cyc != vram_pkg::CYC_COPY && pin.cas_n && pin.xfer_n &&
    !pin.we_n && !pin.fsel |=> st.mask == $past(pin.dq))
    else $error("write mask not captured at row fall");
  a_read_dir_out: assert property (copy_last &&
    st.xk != vram_pkg::XK_WRITE |=> st.out_mode)
    else $error("buffer not output after read transfer");
  a_ptr_wrap_step: assert property (clk_rise && !finish |=>
    st.ptr == $past(st.ptr) + vram_pkg::PTR_STEP)
    else $error("serial pointer did not step by one");
  a_pseudo_input: assert property (st.cyc == vram_pkg::CYC_XFER &&
    st.xk == vram_pkg::XK_PSEUDO && cas_fall && !st.wr_done |=>
    !st.out_mode && st.cyc == vram_pkg::CYC_XFER)
    else $error("pseudo transfer did not select input");
  a_split_half: assert property (st.split_mode |->
    split_half_flag == st.ptr[vram_pkg::HALF_BIT])
    else $error("half flag disagrees with pointer");
  a_tap_flag: assert property (finish &&
    st.xk != vram_pkg::XK_SPLIT |=> st.ptr == st.tap &&
    split_half_flag == st.tap[vram_pkg::HALF_BIT])
    else $error("flag does not follow tap after transfer");
  a_refr_row_step: assert property (ras_fall && !pin.cas_n &&
    st.cyc != vram_pkg::CYC_COPY |=> st.cyc == vram_pkg::CYC_REFR &&
    st.rfsh_row == $past(st.rfsh_row) + vram_pkg::PTR_STEP)
    else $error("refresh counter did not advance");
  a_color_hold: assert property ($changed(st.color) |->
    $past(color_load))
    else $error("color register changed without load");

  c_refresh: cover property (st.cyc == vram_pkg::CYC_REFR);
  c_read_xfer: cover property (finish && st.xk == vram_pkg::XK_READ);
  c_block_wr: cover property (dram_wr && blk);
  c_serial_out: cover property (clk_rise && serial_dq_oe);

endmodule

/* core/vram_pkg.sv */
// shared constants, types and state layout for the video dram control
// assumes the includer compiles this package first

package vram_pkg;

  localparam int ADDR_W     = 9;
  localparam int DQ_W       = 4;
  localparam int DRAM_WORDS = 262144;
  localparam int BUF_WORDS  = 512;
  localparam int HALF_BIT   = 8;
  localparam int BLK_LSB    = 2;
  localparam int AXI_AW     = 12;

  localparam logic [8:0] BUF_FIRST  = 9'h000;
  localparam logic [8:0] PTR_LAST   = 9'h1FF;
  localparam logic [8:0] PTR_STEP   = 9'h001;
  localparam logic [7:0] HALF_FIRST = 8'h00;
  localparam logic [7:0] HALF_LAST  = 8'hFF;
  localparam logic [3:0] MASK_ALL   = 4'hF;

  // register map, byte addresses
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_MASKS  = 12'h008;
  localparam int          CTRL_SER_EN = 0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // synchronised pin snapshot
  typedef struct packed {
    logic             ras_n;
    logic             cas_n;
    logic             xfer_n;
    logic             we_n;
    logic             fsel;
    logic             ser_gate_n;
    logic             ser_clk;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]  dq;
    logic [DQ_W-1:0]  sdq;
  } pins_t;

  localparam pins_t PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, xfer_n: 1'b1,
    we_n: 1'b1, fsel: 1'b0, ser_gate_n: 1'b1, ser_clk: 1'b0, addr: 9'h000,
    dq: 4'h0, sdq: 4'h0};

  typedef enum logic [2:0] {
    CYC_IDLE = 3'h0,
    CYC_RAND = 3'h1,
    CYC_XFER = 3'h2,
    CYC_COPY = 3'h3,
    CYC_REFR = 3'h6
  } cyc_t;

  typedef enum logic [1:0] {
    XK_READ   = 2'h0,
    XK_SPLIT  = 2'h1,
    XK_PSEUDO = 2'h2,
    XK_WRITE  = 2'h3
  } xk_t;

  typedef struct packed {
    pins_t       prev;
    cyc_t        cyc;
    xk_t         xk;
    logic [8:0]  row;
    logic [8:0]  col;
    logic [8:0]  tap;
    logic [8:0]  idx;
    logic [8:0]  ptr;
    logic [8:0]  rfsh_row;
    logic        we_ras;
    logic        fsel_ras;
    logic        fsel_cas;
    logic        wr_done;
    logic [3:0]  mask;
    logic [3:0]  color;
    logic [3:0]  rd_data;
    logic [3:0]  ser_out;
    logic        out_mode;
    logic        split_mode;
    logic        split_flag;
    logic        ser_en;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_t;

endpackage

/* core/pin_sync.sv */
// two-stage synchroniser for a group of asynchronous pins
// assumes the inputs are quiet at reset value while reset is held
`timescale 1ns/1ps

module pin_sync #(
  parameter int           W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [1:0][W-1:0] st;
  logic [1:0][W-1:0] next_st;

  // first stage feeds only the second
  always_comb
  begin
    next_st = {st[0], d};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= {RST_VAL, RST_VAL};
    else
      st <= next_st;
  end

  assign q = st[1];

endmodule

/* bench/vram_host.sv */
// controller-side model: strobe cycles, refresh and the serial clock
// assumes the device samples all pins on aclk; pins change after edges
`timescale 1ns/1ps

module vram_host (
  input  wire logic       aclk,
  input  wire logic [3:0] random_dq_out,
  input  wire logic       random_dq_oe,
  output logic            row_strobe_n,
  output logic            column_strobe_n,
  output logic            transfer_output_enable_n,
  output logic            write_select_n,
  output logic            special_function_select,
  output logic            serial_enable_n,
  output logic            serial_clock,
  output logic [8:0]      address,
  output logic [3:0]      random_dq_in
);
  logic [3:0] drv;
  logic       drv_oe;

  // shared data wire: device first, then host, else a moving value
  assign random_dq_in = random_dq_oe ? random_dq_out :
                        drv_oe ? drv : ~random_dq_out;

  // idle levels; the serial clock stands low outside bursts
  initial
  begin
    row_strobe_n = 1'h1;
    column_strobe_n = 1'h1;
    transfer_output_enable_n = 1'h1;
    write_select_n = 1'h1;
    special_function_select = 1'h0;
    serial_enable_n = 1'h0;
    serial_clock = 1'h0;
    address = 9'h000;
    drv = 4'h0;
    drv_oe = 1'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // one strobe cycle; k = {xfer, ws, fsel at row, fsel at column, sen}
  // wm: 0 read, 1 early write, 2 late write
  task automatic cyc(input logic [4:0] k, input logic [8:0] row, col,
                     input logic [3:0] mdq, wdq, input logic [1:0] wm,
                     output logic [3:0] q, output logic oe);
    @(posedge aclk);
    address <= row;
    transfer_output_enable_n <= k[4];
    write_select_n <= k[3];
    special_function_select <= k[2];
    serial_enable_n <= k[0];
    drv <= mdq;
    drv_oe <= 1'h1;
    wt(2);
    row_strobe_n <= 1'h0;
    wt(4);
    address <= col;
    special_function_select <= k[1];
    drv <= wdq;
    drv_oe <= wm != 2'h0;
    write_select_n <= k[3] & (wm != 2'h1);
    transfer_output_enable_n <= k[4] & (wm != 2'h0);
    wt(2);
    column_strobe_n <= 1'h0;
    wt(3);
    if (wm == 2'h2)
      write_select_n <= 1'h0;
    wt(5);
    q = random_dq_out;
    oe = random_dq_oe;
    row_strobe_n <= 1'h1;
    column_strobe_n <= 1'h1;
    transfer_output_enable_n <= 1'h1;
    write_select_n <= 1'h1;
    special_function_select <= 1'h0;
    serial_enable_n <= 1'h0;
    drv_oe <= 1'h0;
    wt(6);
  endtask

  // column low ahead of row, write_select kept high
  task automatic rfsh();
    @(posedge aclk);
    column_strobe_n <= 1'h0;
    wt(4);
    row_strobe_n <= 1'h0;
    wt(4);
    row_strobe_n <= 1'h1;
    column_strobe_n <= 1'h1;
    wt(4);
  endtask

  // serial clock burst at 125 ns period, off the aclk grid
  task automatic sclk(input int n);
    repeat (n)
    begin
      #62.5 serial_clock = 1'h1;
      #62.5 serial_clock = 1'h0;
    end
    wt(6);
  endtask

  // start-up: short pause, eight refreshes, read transfer, two clocks
  task automatic powerup(input logic [8:0] row);
    logic [3:0] q;
    logic       oe;
    wt(50);
    repeat (8) rfsh();
    cyc(5'h08, row, 9'h000, 4'h0, 4'h0, 2'h0, q, oe);
    wt(600);
    sclk(2);
  endtask
endmodule

/* bench/dual_port_video_dram_control_tb.sv */
// self-checking bench for the video dram control block
// assumes vram_pkg, the design and vram_host are compiled first
`timescale 1ns/1ps

module dual_port_video_dram_control_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, dq_in, dq_out, sdq_in, sdq_out, sin;
  logic [1:0]  bresp, rresp;
  logic        ras_n, cas_n, toe_n, ws_n, fsel, sen_n, ser_clk;
  logic        dq_oe, sdq_oe, flag;
  logic [8:0]  addr;
  logic [3:0]  mem [4];
  int          fail_count, total_checks;

  vram_control i_vram_control (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .row_strobe_n(ras_n),
    .column_strobe_n(cas_n), .transfer_output_enable_n(toe_n),
    .write_select_n(ws_n), .special_function_select(fsel),
    .serial_enable_n(sen_n), .serial_clock(ser_clk), .address(addr),
    .random_dq_in(dq_in), .random_dq_out(dq_out), .random_dq_oe(dq_oe),
    .serial_dq_in(sdq_in), .serial_dq_out(sdq_out), .serial_dq_oe(sdq_oe),
    .split_half_flag(flag));

  vram_host host (
    .aclk(aclk), .random_dq_out(dq_out), .random_dq_oe(dq_oe),
    .row_strobe_n(ras_n), .column_strobe_n(cas_n),
    .transfer_output_enable_n(toe_n), .write_select_n(ws_n),
    .special_function_select(fsel), .serial_enable_n(sen_n),
    .serial_clock(ser_clk), .address(addr), .random_dq_in(dq_in));

  // serial wire: a moving value while the device drives it
  assign sdq_in = sdq_oe ? ~sdq_out : sin;

  initial
  begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  function automatic logic [3:0] mrg(input logic [3:0] o, n, m);
    return (n & m) | (o & ~m);
  endfunction

  // status word: flag, split, output mode, pointer; refresh row left zero
  function automatic logic [31:0] st(input logic [8:0] p,
                                     input logic om, sm, fl);
    return {20'h00000, fl, sm, om, p};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // register write: address and data offered together
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge aclk); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] m, e,
                      input string n);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(n, e & m, d & m);
  endtask

  // wait until the buffer copy has finished
  task automatic idle();
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h00001000;
    for (int i = 0; i < 1000 && d[12] !== 1'h0; i++)
      axr(vram_pkg::OFS_STATUS, d, r);
    chk("copy busy", 32'h0, 32'(d[12]));
  endtask

  task automatic rdblk(input logic [8:0] row, col);
    logic [3:0] q;
    logic       oe;
    for (int k = 0; k < 4; k++)
    begin
      host.cyc(5'h18, row, col + 9'(k), 4'h0, 4'h0, 2'h0, q, oe);
      chk("dq_oe", 32'h1, 32'(oe));
      chk("dq", 32'(mem[k]), 32'(q));
    end
  endtask

  // hang guard well beyond the expected run
  initial
  begin
    #100000;
    fail_count++;
    summarize();
  end

  // reset, registers, array access, transfers and serial traffic
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [8:0]  row;
    logic [3:0]  q, m, v, c;
    logic        oe;
    fail_count = 0;
    total_checks = 0;
    aresetn = 1'h0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, sin} = '0;
    wstrb = 4'hF;
    void'($urandom(32'h2CF586FA));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rchk(vram_pkg::OFS_CTRL, 32'h1, 32'h1, "ctrl");
    rchk(vram_pkg::OFS_STATUS, '1, 32'h0, "status");
    axw(12'h010, 32'h0, r);
    chk("wr resp", 32'(vram_pkg::RESP_SLVERR), 32'(r));
    axr(12'h00C, d, r);
    chk("rd resp", 32'(vram_pkg::RESP_SLVERR), 32'(r));
    sin <= 4'($urandom);
    row = 9'($urandom);
    host.powerup(row);
    rchk(vram_pkg::OFS_STATUS, '1, 32'h00080202, "startup");
    for (int k = 0; k < 4; k++)
    begin
      mem[k] = 4'($urandom);
      host.cyc(5'h18, row, 9'h1FC + 9'(k), 4'h0, mem[k],
               (k == 3) ? 2'h2 : 2'h1, q, oe);
    end
    m = 4'($urandom);
    v = 4'($urandom);
    host.cyc(5'h10, row, 9'h1FC, m, v, 2'h1, q, oe);
    mem[0] = mrg(mem[0], v, m);
    m = 4'($urandom);
    v = 4'($urandom);
    host.cyc(5'h1C, row, 9'h000, 4'h0, m, 2'h1, q, oe);
    host.cyc(5'h14, row, 9'h1FD, ~m, v, 2'h1, q, oe);
    mem[1] = mrg(mem[1], v, m);
    c = 4'($urandom);
    host.cyc(5'h1E, row, 9'h000, 4'h0, c, 2'h1, q, oe);
    rchk(vram_pkg::OFS_MASKS, 32'hFF, {24'h0, c, m}, "masks");
    v = 4'($urandom);
    host.cyc(5'h1A, row, 9'h1FC, 4'h0, v, 2'h1, q, oe);
    for (int k = 0; k < 4; k++)
      if (v[k])
        mem[k] = c;
    rdblk(row, 9'h1FC);
    host.cyc(5'h08, row, 9'h1FC, 4'h0, 4'h0, 2'h0, q, oe);
    chk("xfer dq_oe", 32'h0, 32'(oe));
    idle();
    rchk(vram_pkg::OFS_STATUS, 32'hFFF, st(9'h1FC, 1'h1, 1'h0, 1'h1),
         "read xfer");
    for (int k = 0; k < 4; k++)
    begin
      host.sclk(1);
      chk("sdq", 32'(mem[k]), 32'(sdq_out));
    end
    chk("sdq_oe", 32'h1, 32'(sdq_oe));
    rchk(vram_pkg::OFS_STATUS, 32'h1FF, 32'h0, "wrap");
    axw(vram_pkg::OFS_CTRL, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk("sdq_oe off", 32'h0, 32'(sdq_oe));
    axw(vram_pkg::OFS_CTRL, 32'h1, r);
    host.cyc(5'h01, row, 9'h055, 4'h0, 4'h0, 2'h0, q, oe);
    idle();
    rchk(vram_pkg::OFS_STATUS, 32'h3FF, 32'h055, "pseudo");
    chk("sdq_oe in", 32'h0, 32'(sdq_oe));
    v = 4'($urandom);
    sin <= v;
    host.sclk(1);
    host.cyc(5'h00, row, 9'h000, 4'h0, 4'h0, 2'h0, q, oe);
    idle();
    host.cyc(5'h18, row, 9'h055, 4'h0, 4'h0, 2'h0, q, oe);
    chk("wr xfer", 32'(v), 32'(q));
    host.cyc(5'h08, row, 9'h0FE, 4'h0, 4'h0, 2'h0, q, oe);
    idle();
    host.cyc(5'h0C, row, 9'h000, 4'h0, 4'h0, 2'h0, q, oe);
    idle();
    rchk(vram_pkg::OFS_STATUS, 32'hFFF, st(9'h0FE, 1'h1, 1'h1, 1'h0),
         "split low");
    host.sclk(2);
    chk("flag", 32'h1, 32'(flag));
    rchk(vram_pkg::OFS_STATUS, 32'hFFF, st(9'h100, 1'h1, 1'h1, 1'h1),
         "split high");
    summarize();
  end
endmodule
